// File: dosc_clock_ctrl.sv
// Clock source select, divide by two, stop and wait control with APB registers
`timescale 1ns/10ps
// Summary of operation
// - Ordinary mode clock is main oscillator halved
// - Low-speed mode clock is sub oscillator halved
// - Reset gives ordinary mode, main only, ports
// - Bit 4 hands shared pins to sub oscillator
// - Bit 5 selects sub drive high or low
// - Bit 7 selects sub or main source
// - Bit 6 stops the main oscillator
// - Stop instruction halts every oscillator
// - Reset or wake interrupt leaves stop
// - Wait instruction gates only the CPU clock
// - Reset or any interrupt leaves wait
// - CPU and peripherals share one divided clock
// - Stop exit waits 32768 oscillator counts
// - Stop instruction loads timers 3 and 4
module dosc_clock_ctrl
  import dosc_pkg::*;
#(
  parameter logic [7:0] T3_LOAD = T3_STOP_LOAD, // Shorten for simulation
  parameter logic [7:0] T4_LOAD = T4_STOP_LOAD, // Shorten for simulation
  parameter int PRE_W = PRESCALE_W // Prescaler width, 16 edges per tick
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  input wire logic halt_all_osc_instr,
  input wire logic cpu_clock_gate_instr,
  input wire logic wake_irq,
  input wire logic any_irq,
  output logic phi_cpu,
  output logic phi_periph,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic sub_drive_high,
  output logic port_sub_osc_sel
);

  // All state of the controller in one record
  typedef struct packed {
    logic [7:0] cm; // CPU mode control register
    dosc_mode_type mode; // Power mode
    logic sel_act; // Source actually driving the divider, 1 = sub
    logic phi; // Divided internal clock
    logic cpu_on; // CPU clock gate, changes only while phi is low
    logic phi_cpu; // Gated CPU clock
    logic main_en; // Main oscillator enable
    logic sub_en; // Sub oscillator enable
    logic [7:0] t3; // Stabilisation timer 3
    logic [7:0] t4; // Stabilisation timer 4
    logic [PRE_W-1:0] pre; // Divide-by-16 prescaler ahead of timer 3
    logic [31:0] rdata; // APB read data
    logic ready; // APB ready
    logic slverr; // APB error
  } dosc_ctrl_state_type;

  // Values after reset: ordinary mode, main oscillator only
  localparam dosc_ctrl_state_type RESET_STATE = '{
    cm: CM_RESET,
    mode: M_RUN,
    sel_act: 1'b0,
    phi: 1'b0,
    cpu_on: 1'b1,
    phi_cpu: 1'b0,
    main_en: 1'b1,
    sub_en: 1'b0,
    t3: T3_LOAD,
    t4: T4_LOAD,
    pre: '0,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0
  };

  dosc_ctrl_state_type st_reg;
  dosc_ctrl_state_type st_next;

  // Edge taps for the two oscillators
  dosc_osc_if main_if ();
  dosc_osc_if sub_if ();

  assign main_if.osc_in = main_osc_in;
  assign main_if.run = st_reg.main_en;
  assign sub_if.osc_in = sub_osc_in;
  assign sub_if.run = st_reg.sub_en;

  // Main oscillator edges
  dosc_osc_tap u_main_tap (
    .mclk(mclk),
    .rst(rst),
    .osc(main_if.tap)
  );

  // Sub oscillator edges
  dosc_osc_tap u_sub_tap (
    .mclk(mclk),
    .rst(rst),
    .osc(sub_if.tap)
  );

  logic sel_rise; // Edge of the source that drives the divider
  logic [31:0] stat_word; // Status register image
  logic wr_cm; // Write strobe for the mode register
  logic acc_ph; // APB setup cycle seen, answer due

  // Edge source follows the active selection, not the requested one
  assign sel_rise = st_reg.sel_act ? sub_if.rise : main_if.rise;

  // Status image, unused bits read as zero
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_MODE_LSB +: $bits(dosc_mode_type)] = st_reg.mode;
    stat_word[STAT_SEL_BIT] = st_reg.sel_act;
    stat_word[STAT_CPU_BIT] = st_reg.cpu_on;
    stat_word[STAT_PHI_BIT] = st_reg.phi;
    stat_word[STAT_T3_LSB +: 8] = st_reg.t3;
    stat_word[STAT_T4_LSB +: 8] = st_reg.t4;
  end

  // Register write happens at the access edge where ready is high
  assign acc_ph = psel && !penable && !st_reg.ready;
  assign wr_cm = psel && penable && st_reg.ready && pwrite && (paddr == CM_OFFSET);

  // Next-state logic for bus, power modes, timers, divider and gates
  always_comb begin
    st_next = st_reg;

    // APB: answer one cycle after setup, in the first access cycle
    st_next.ready = 1'b0;
    st_next.slverr = 1'b0;
    if (acc_ph) begin
      st_next.ready = 1'b1;
      case (paddr)
        CM_OFFSET: begin
          st_next.rdata = {24'h00_0000, st_reg.cm};
        end
        STAT_OFFSET: begin
          st_next.rdata = stat_word;
          // Status is read-only, a write is refused
          st_next.slverr = pwrite;
        end
        default: begin
          // Unmapped address reads zero and reports an error
          st_next.rdata = 32'h0000_0000;
          st_next.slverr = 1'b1;
        end
      endcase
    end
    if (wr_cm) begin
      st_next.cm = pwdata[7:0];
    end

    // Power mode sequencing
    case (st_reg.mode)
      M_RUN: begin
        if (halt_all_osc_instr) begin
          // Stop has priority over wait if both arrive together
          st_next.mode = M_STOP;
          st_next.t3 = T3_LOAD;
          st_next.t4 = T4_LOAD;
          st_next.pre = '0;
        end else if (cpu_clock_gate_instr) begin
          st_next.mode = M_WAIT;
        end
      end
      M_WAIT: begin
        if (any_irq) begin
          st_next.mode = M_RUN;
        end
      end
      M_STOP: begin
        // Only permitted wake sources restart the oscillators
        if (wake_irq) begin
          st_next.mode = M_STAB;
        end
      end
      M_STAB: begin
        // Timer 3 ticks every 16 edges, timer 4 on each timer 3 underflow
        if (sel_rise) begin
          st_next.pre = st_reg.pre + 1'b1;
          if (&st_reg.pre) begin
            if (st_reg.t3 == 8'h00) begin
              st_next.t3 = T3_LOAD;
              if (st_reg.t4 == 8'h00) begin
                st_next.mode = M_RUN;
              end else begin
                st_next.t4 = st_reg.t4 - 1'b1;
              end
            end else begin
              st_next.t3 = st_reg.t3 - 1'b1;
            end
          end
        end
      end
      default: begin
        st_next.mode = M_RUN;
      end
    endcase

    // Oscillator enables, both off in stop mode
    st_next.main_en = (st_next.mode != M_STOP) && !st_next.cm[CM_MAIN_STOP_BIT];
    st_next.sub_en = (st_next.mode != M_STOP) && st_next.cm[CM_PORT_SEL_BIT];

    // Source switch only while phi is low, so no high phase is cut short;
    // the low phase may stretch until the new source gives an edge
    if (!st_reg.phi && (st_reg.sel_act != st_reg.cm[CM_CLK_SEL_BIT])) begin
      st_next.sel_act = st_reg.cm[CM_CLK_SEL_BIT];
    end else if (sel_rise) begin
      // Toggle on every source rising edge gives division by two
      st_next.phi = !st_reg.phi;
    end

    // CPU gate moves only while phi is low, keeping CPU pulses whole
    if (!st_reg.phi) begin
      st_next.cpu_on = (st_reg.mode == M_RUN) && (st_next.mode == M_RUN);
    end
    // CPU and peripherals see the same divided clock
    st_next.phi_cpu = st_next.cpu_on & st_next.phi;
  end

  // State register; synchronous reset returns to ordinary mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.slverr;
  assign phi_cpu = st_reg.phi_cpu;
  assign phi_periph = st_reg.phi;
  assign main_osc_en = st_reg.main_en;
  assign sub_osc_en = st_reg.sub_en;
  assign sub_drive_high = st_reg.cm[CM_DRIVE_BIT];
  assign port_sub_osc_sel = st_reg.cm[CM_PORT_SEL_BIT];

  // Checks on the controller, all in the mclk domain
  default clocking dosc_cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  reset_mode_a: assert property (
    $fell(rst) |-> (st_reg.mode == M_RUN) && !st_reg.sel_act && main_osc_en
      && !sub_osc_en && !port_sub_osc_sel)
    else $error("reset release did not give ordinary mode with main only");

  main_div_a: assert property (
    !$stable(phi_periph) && !st_reg.sel_act |-> $past(main_if.rise))
    else $error("divided clock moved without a main oscillator edge");

  sub_div_a: assert property (
    !$stable(phi_periph) && st_reg.sel_act |-> $past(sub_if.rise))
    else $error("divided clock moved without a sub oscillator edge");

  pin_assign_a: assert property (
    wr_cm |=> port_sub_osc_sel == $past(pwdata[CM_PORT_SEL_BIT]))
    else $error("shared pin assignment did not follow the written bit");

  drive_level_a: assert property (
    wr_cm |=> sub_drive_high == $past(pwdata[CM_DRIVE_BIT]))
    else $error("sub drive level did not follow the written bit");

  source_follow_a: assert property (
    !phi_periph && (st_reg.sel_act != st_reg.cm[CM_CLK_SEL_BIT])
      |=> st_reg.sel_act == $past(st_reg.cm[CM_CLK_SEL_BIT]))
    else $error("clock source did not follow the select bit");

  main_stop_a: assert property (
    st_reg.cm[CM_MAIN_STOP_BIT] |-> !main_osc_en)
    else $error("main oscillator ran while its stop bit was set");

  stop_halt_a: assert property (
    (st_reg.mode == M_STOP) |-> !main_osc_en && !sub_osc_en)
    else $error("an oscillator ran in stop mode");

  stop_wake_a: assert property (
    (st_reg.mode == M_STOP) && wake_irq |=> (st_reg.mode == M_STAB)
      && (main_osc_en == !st_reg.cm[CM_MAIN_STOP_BIT]))
    else $error("wake request did not restart the oscillators");

  wait_gate_a: assert property (
    (st_reg.mode == M_WAIT) && !phi_cpu |=> !phi_cpu)
    else $error("CPU clock ran in wait mode");

  wait_exit_a: assert property (
    (st_reg.mode == M_WAIT) && any_irq |=> (st_reg.mode == M_RUN))
    else $error("interrupt did not end wait mode");

  shared_clock_a: assert property (
    st_reg.cpu_on |-> phi_cpu == phi_periph)
    else $error("CPU clock differs from peripheral clock");

  stab_count_a: assert property (
    (st_reg.mode == M_RUN) && ($past(st_reg.mode) == M_STAB)
      |-> $past(st_reg.t3) == 8'h00 && $past(st_reg.t4) == 8'h00 && &$past(st_reg.pre))
    else $error("stop recovery ended before the stabilisation count");

  timer_load_a: assert property (
    (st_reg.mode == M_RUN) && halt_all_osc_instr
      |=> (st_reg.mode == M_STOP) && st_reg.t3 == T3_LOAD && st_reg.t4 == T4_LOAD)
    else $error("stop instruction did not load the stabilisation timers");

  clean_switch_a: assert property (
    !$stable(st_reg.sel_act) |-> !phi_periph && !$past(phi_periph))
    else $error("clock source switched while the clock was high");

endmodule : dosc_clock_ctrl

// File: dosc_osc_if.sv
// Interface between the clock controller and one oscillator edge tap
`timescale 1ns/10ps
interface dosc_osc_if;
  logic osc_in; // Sampled oscillator level
  logic run; // Oscillator enabled
  logic rise; // One-cycle pulse per oscillator rising edge
  modport tap (input osc_in, input run, output rise);
  modport user (output osc_in, output run, input rise);
endinterface : dosc_osc_if

// File: dosc_osc_tap.sv
// Rising edge detector for one oscillator input, silent while stopped
`timescale 1ns/10ps
module dosc_osc_tap (
  input wire logic mclk,
  input wire logic rst,
  dosc_osc_if.tap osc
);

  // Tap state: last seen level and the edge pulse
  typedef struct packed {
    logic last;
    logic rise;
  } dosc_tap_state_type;

  dosc_tap_state_type tap_reg;
  dosc_tap_state_type tap_next;

  // A stopped oscillator yields no edges, whatever the pin shows
  always_comb begin
    tap_next = tap_reg;
    tap_next.last = osc.osc_in & osc.run;
    tap_next.rise = osc.run & osc.osc_in & ~tap_reg.last;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      // Track the pin through reset so a high level at release is no edge
      tap_reg <= '{last: tap_next.last, rise: 1'b0};
    end else begin
      tap_reg <= tap_next;
    end
  end

  assign osc.rise = tap_reg.rise;

  // An edge pulse never lasts two cycles
  edge_single_a: assert property (@(posedge mclk) disable iff (rst)
    osc.rise |=> !osc.rise)
    else $error("oscillator edge pulse lasted two cycles");

endmodule : dosc_osc_tap

// File: dosc_pkg.sv
// Shared constants and types for the dual oscillator clock select block
package dosc_pkg;

  // APB address width and register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] CM_OFFSET = 12'h000;
  localparam logic [11:0] STAT_OFFSET = 12'h004;

  // CPU mode control register: reset value and bit positions
  localparam logic [7:0] CM_RESET = 8'h00;
  localparam int CM_PORT_SEL_BIT = 4;
  localparam int CM_DRIVE_BIT = 5;
  localparam int CM_MAIN_STOP_BIT = 6;
  localparam int CM_CLK_SEL_BIT = 7;

  // Stabilisation timers loaded by the stop instruction
  localparam logic [7:0] T3_STOP_LOAD = 8'hff;
  localparam logic [7:0] T4_STOP_LOAD = 8'h07;
  // Timer 3 counts the selected oscillator divided by 16
  localparam int PRESCALE_W = 4;

  // Status register field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SEL_BIT = 2;
  localparam int STAT_CPU_BIT = 3;
  localparam int STAT_PHI_BIT = 4;
  localparam int STAT_T3_LSB = 8;
  localparam int STAT_T4_LSB = 16;

  // Power modes of the device
  typedef enum logic [1:0] {
    M_RUN,
    M_WAIT,
    M_STOP,
    M_STAB
  } dosc_mode_type;

endpackage : dosc_pkg

// File: tb_dual_oscillator_clock_select.sv
// Self-checking testbench for the dual oscillator clock select block
`timescale 1ns/10ps
module tb_dual_oscillator_clock_select;
  import dosc_pkg::*;
  localparam logic [7:0] T3_SIM = 8'h01; // Short stabilisation load
  localparam logic [7:0] T4_SIM = 8'h00;
  // Main edges counted on stop recovery; main gives one edge per 4 cycles
  localparam int STAB_CYC = 4 * 16 * (T3_SIM + 1) * (T4_SIM + 1);
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, phi_cpu, phi_periph;
  logic main_osc_en, sub_osc_en, sub_drive_high, port_sub_osc_sel;
  logic main_osc_in = 1'b0;
  logic sub_osc_in = 1'b0;
  logic halt = 1'b0;
  logic gate = 1'b0;
  logic wake = 1'b0;
  logic irq = 1'b0;
  logic [3:0] osc_cnt = 4'h0; // Common divider for both oscillator stand-ins
  int cyc = 0; // Free cycle count for measuring spans
  int fails = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  int n;
  int t0;

  always #2 mclk = ~mclk;

  // Main toggles every 2 cycles, sub every 8, so sub runs four times slower
  always @(posedge mclk) begin
    osc_cnt <= osc_cnt + 4'h1;
    main_osc_in <= osc_cnt[1];
    sub_osc_in <= osc_cnt[3];
    cyc <= cyc + 1;
  end

  dosc_clock_ctrl #(.T3_LOAD(T3_SIM), .T4_LOAD(T4_SIM), .PRE_W(PRESCALE_W)) u_dosc_clock_ctrl (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .halt_all_osc_instr(halt),
    .cpu_clock_gate_instr(gate), .wake_irq(wake), .any_irq(irq), .phi_cpu(phi_cpu),
    .phi_periph(phi_periph), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .sub_drive_high(sub_drive_high), .port_sub_osc_sel(port_sub_osc_sel));

  // Compare one value, four-state exact
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; pready, read data and error are all taken at a rising edge,
  // and the request stands until that edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) chk("pready", 1, 0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Mode register write, then let the registered outputs settle
  task cm_wr(input logic [7:0] v);
    apb(1'b1, CM_OFFSET, {24'h0, v});
    @(negedge mclk);
  endtask : cm_wr

  // One-cycle instruction or interrupt pulse; 4 means stop and wait together
  task pulse(input int which);
    @(posedge mclk);
    case (which)
      0: halt <= 1'b1;
      1: gate <= 1'b1;
      2: wake <= 1'b1;
      3: irq <= 1'b1;
      default: begin
        halt <= 1'b1;
        gate <= 1'b1;
      end
    endcase
    @(posedge mclk);
    halt <= 1'b0;
    gate <= 1'b0;
    wake <= 1'b0;
    irq <= 1'b0;
  endtask : pulse

  // Count rising edges of the peripheral or CPU clock over a span
  task rises(input int span, input logic cpu, output int cnt);
    logic last;
    last = cpu ? phi_cpu : phi_periph;
    cnt = 0;
    repeat (span) begin
      @(negedge mclk);
      if ((cpu ? phi_cpu : phi_periph) === 1'b1 && last === 1'b0) cnt++;
      last = cpu ? phi_cpu : phi_periph;
    end
  endtask : rises

  task test_reset;
    chk("main_osc_en", 1, main_osc_en);
    chk("sub_osc_en", 0, sub_osc_en);
    chk("port_sub_osc_sel", 0, port_sub_osc_sel);
    chk("sub_drive_high", 0, sub_drive_high);
    apb(1'b0, CM_OFFSET, 32'h0);
    chk("mode reg reset", {24'h0, CM_RESET}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 1, er);
    apb(1'b1, STAT_OFFSET, 32'h0000_00ff);
    chk("status write err", 1, er);
    $display("test_reset done");
  endtask : test_reset

  task test_main_rate;
    rises(320, 1'b0, n);
    chk("phi main rate", 1, n >= 39 && n <= 41);
    rises(320, 1'b1, n);
    chk("cpu clock rate", 1, n >= 39 && n <= 41);
    pulse(2);
    pulse(3);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("irq ignored in run", 0, rd[STAT_MODE_LSB +: 2]);
    $display("test_main_rate done");
  endtask : test_main_rate

  task test_low_speed;
    cm_wr(8'h10);
    chk("pins to sub", 1, port_sub_osc_sel);
    chk("sub running", 1, sub_osc_en);
    cm_wr(8'h30);
    chk("drive high", 1, sub_drive_high);
    // Software settle wait before switching
    repeat (64) @(posedge mclk);
    cm_wr(8'hb0);
    repeat (40) @(posedge mclk);
    rises(320, 1'b0, n);
    chk("phi sub rate", 1, n >= 9 && n <= 11);
    cm_wr(8'hf0);
    chk("main stopped", 0, main_osc_en);
    rises(320, 1'b0, n);
    chk("phi sub rate main off", 1, n >= 9 && n <= 11);
    cm_wr(8'hb0);
    chk("main restarted", 1, main_osc_en);
    repeat (64) @(posedge mclk);
    cm_wr(8'h30);
    repeat (40) @(posedge mclk);
    rises(320, 1'b0, n);
    chk("phi back to main", 1, n >= 39 && n <= 41);
    cm_wr(8'h10);
    chk("drive low", 0, sub_drive_high);
    cm_wr(8'h00);
    chk("pins to port", 0, port_sub_osc_sel);
    $display("test_low_speed done");
  endtask : test_low_speed

  task test_wait;
    pulse(1);
    repeat (16) @(posedge mclk);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("wait mode", 1, rd[STAT_MODE_LSB +: 2]);
    rises(200, 1'b1, n);
    chk("cpu gated", 0, n);
    rises(200, 1'b0, n);
    chk("periph runs", 1, n >= 24 && n <= 26);
    chk("osc kept", 1, main_osc_en);
    pulse(3);
    repeat (16) @(posedge mclk);
    rises(160, 1'b1, n);
    chk("cpu resumed", 1, n >= 19 && n <= 21);
    $display("test_wait done");
  endtask : test_wait

  task test_stop;
    pulse(4);
    @(negedge mclk);
    chk("main halted", 0, main_osc_en);
    chk("sub halted", 0, sub_osc_en);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("stop mode", 2, rd[STAT_MODE_LSB +: 2]);
    chk("t3 load", T3_SIM, rd[STAT_T3_LSB +: 8]);
    chk("t4 load", T4_SIM, rd[STAT_T4_LSB +: 8]);
    rises(100, 1'b0, n);
    chk("no clock in stop", 0, n);
    pulse(2);
    t0 = cyc;
    @(negedge mclk);
    chk("osc restart", 1, main_osc_en);
    apb(1'b0, STAT_OFFSET, 32'h0);
    chk("stab mode", 3, rd[STAT_MODE_LSB +: 2]);
    n = 0;
    while (rd[STAT_MODE_LSB +: 2] !== 2'd0 && n < 200) begin
      apb(1'b0, STAT_OFFSET, 32'h0);
      n++;
    end
    chk("stab span", 1, cyc - t0 >= STAB_CYC - 8 && cyc - t0 <= STAB_CYC + 24);
    rises(160, 1'b1, n);
    chk("cpu after stop", 1, n >= 19 && n <= 21);
    $display("test_stop done");
  endtask : test_stop

  // Single closing point for normal end and timeout alike
  task wrap_up;
    $display("Checks made %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Watchdog: the tests need about 2900 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    test_reset();
    test_main_rate();
    test_low_speed();
    test_wait();
    test_stop();
    wrap_up();
  end
endmodule : tb_dual_oscillator_clock_select
